// ---- rtl/wes_defines.svh ----
`ifndef WES_DEFINES_SVH
`define WES_DEFINES_SVH
// register byte offsets
`define WES_OFF_PWR_CTRL     12'h084
`define WES_OFF_BYTE_TEST    12'h064
`define WES_OFF_HARDWARE_CONFIG_REG       12'h074
`define WES_OFF_EVENT_SRC    12'h0f0
// field positions in power_wake_control
`define WES_BIT_READY        0
`define WES_BIT_OUT_EN       1
`define WES_BIT_POL          2
`define WES_BIT_PULSE_SEL    3
`define WES_BIT_CAUSE_LO     4
`define WES_BIT_CAUSE_HI     5
`define WES_BIT_DRIVE_TYPE   6
`define WES_BIT_ENERGY_EN    8
`define WES_BIT_FRAME_EN     9
`define WES_BIT_MODE_LO      12
`define WES_BIT_MODE_HI      13
// power state codes
`define WES_MODE_ACTIVE      2'h0
`define WES_MODE_FRAME       2'h1
`define WES_MODE_ENERGY      2'h2
// timing
`define WES_CLK_HZ           20000000
`define WES_PULSE_MS         50
`define WES_PULSE_CYC        ((`WES_CLK_HZ / 1000) * `WES_PULSE_MS)
`define WES_SETTLE_US        10
`define WES_SETTLE_CYC       ((`WES_CLK_HZ / 1000000) * `WES_SETTLE_US)
`endif

// ---- rtl/wes_pkg.sv ----
package wes_pkg;
  // apb request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wes_apb_req_s;
  // apb answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wes_apb_rsp_s;
  // readiness sequencer states, one-hot
  typedef enum logic [2:0] {
    WES_ST_SETTLE = 3'b001,
    WES_ST_READY  = 3'b010,
    WES_ST_SLEEP  = 3'b100
  } wes_state_e;
endpackage : wes_pkg

// ---- rtl/wes_sync2.sv ----
`timescale 1ns/10ps
// two flop synchroniser for pin level inputs
module wes_sync2 #(
  parameter int W = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q; // first stage, read only by second stage

  // plain two stage chain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : wes_sync2

// ---- rtl/wes_pulse_timer.sv ----
`timescale 1ns/10ps
`include "wes_defines.svh"
// one shot timer for the pulsed event output
module wes_pulse_timer #(
  parameter int unsigned PULSE_CYC = `WES_PULSE_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy
);
  logic [20:0] cnt_q; // remaining cycles, wide enough for 50 ms at 20 MHz

  // load on start, count down to zero, abort wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 21'h0;
    else if (abort)
      cnt_q <= 21'h0;
    else if (start)
      cnt_q <= 21'(PULSE_CYC); // RQ21
    else if (cnt_q != 21'h0)
      cnt_q <= cnt_q - 21'h1;
  end

  assign busy = (cnt_q != 21'h0);
endmodule : wes_pulse_timer

// ---- rtl/wes_wake_status.sv ----
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps
`include "wes_defines.svh"
// How it works
// RQ1: cause field: none, energy, frame, both
// RQ2: cause bit clears only on written one
// RQ3: clearing allowed only when active and ready
// RQ4: bit stays set while its source pends
// RQ5: pulse mode drives output for 50 ms
// RQ6: static mode holds output until deactivated
// RQ7: clearing status or enable drops output
// RQ8: polarity bit picks push-pull active level
// RQ9: open-drain ignores polarity, active low
// RQ10: output enable gates the external pin
// RQ11: interrupt independent of output enable
// RQ12: ready flag clear while settling
// RQ13: control register readable in every state
// RQ14: host polls ready after any wake
// RQ15: host touches no other address early
// RQ16: only config and control readable early; the code decodes only control, config reads error
// RQ17: power state codes zero, one, two
// RQ18: byte test write wakes the device
// RQ19: enabled events raise interrupt and output
// RQ20: drive type: clear open-drain, set push-pull
// RQ21: pulse width timed by cycle counter
module wes_wake_status #(
  parameter int unsigned PULSE_CYC  = `WES_PULSE_CYC,
  parameter int unsigned SETTLE_CYC = `WES_SETTLE_CYC
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire wes_pkg::wes_apb_req_s apb_req,
  output wes_pkg::wes_apb_rsp_s      apb_rsp,
  input  wire logic                  energy_event_pin,
  input  wire logic                  frame_event_pin,
  output logic                       power_event_interrupt,
  output logic                       power_event_out,
  output logic                       power_event_oe,
  output logic [1:0]                 power_state_select
);
  import wes_pkg::*;

  logic [1:0]  ev_sync;          // synchronised event levels {frame, energy}
  logic [1:0]  pend_q;           // latched event sources, cleared by software
  logic [1:0]  cause_q;          // wake cause status {frame, energy}
  logic        pulse_sel_q;      // pulsed versus static output
  logic        pol_q;            // push-pull active level
  logic        out_en_q;         // external pin enable
  logic        drive_q;          // 1 push-pull, 0 open-drain
  logic        energy_en_q;      // energy event enable
  logic        frame_en_q;       // frame event enable
  logic [1:0]  mode_q;           // current power state
  wes_state_e  state_q;          // readiness sequencer
  logic [15:0] settle_q;         // settle counter, counts up from zero
  logic        event_active;     // any enabled wake cause set
  logic        event_rise;       // event_active rose this cycle
  logic        event_active_q;   // delayed copy for edge detect
  logic        pulse_busy;       // pulse timer running
  logic        out_active;       // logical output assertion
  logic        wr_fire;          // apb write access phase
  logic        rd_fire;          // apb read access phase
  logic        ready;            // device ready flag
  logic [1:0]  ev_new;           // rising source events
  logic [1:0]  ev_q;             // prior synchronised levels
  logic [1:0]  clr_ok;           // cause bits that software may clear
  logic [31:0] prdata_q;         // registered read data, kept apart from the combinational answer fields

  // address match helper, shared by write and read decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // event pins come from another domain
  wes_sync2 #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({frame_event_pin, energy_event_pin}),
    .dout    (ev_sync)
  );

  assign wr_fire = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_fire = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  assign ready   = (state_q == WES_ST_READY); // RQ12

  // source edges, so a source held high sets cause only once, on its rise; a ready write to the event source reg sets pending again while it is high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ev_q <= 2'h0;
    else
      ev_q <= ev_sync;
  end
  assign ev_new = ev_sync & ~ev_q;

  // pending sources: set by event, cleared by writing one to event source reg
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_q <= 2'h0;
    else if (wr_fire && ready && hit(apb_req.paddr, `WES_OFF_EVENT_SRC))
      pend_q <= (pend_q & ~apb_req.pwdata[1:0]) | ev_new | ev_sync; // set wins
    else
      pend_q <= pend_q | ev_new;
  end

  // a cause bit may only clear in active state, ready, with no source pending
  assign clr_ok[0] = ready && (mode_q == `WES_MODE_ACTIVE) && !pend_q[0] && !ev_sync[0]; // RQ3 RQ4
  assign clr_ok[1] = ready && (mode_q == `WES_MODE_ACTIVE) && !pend_q[1] && !ev_sync[1]; // RQ3 RQ4

  // wake cause status, write one to clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_q <= 2'h0;
    else if (wr_fire && hit(apb_req.paddr, `WES_OFF_PWR_CTRL))
      cause_q <= (cause_q & ~(apb_req.pwdata[`WES_BIT_CAUSE_HI:`WES_BIT_CAUSE_LO] & clr_ok)) // RQ2
                 | ev_new;                                                             // RQ1
    else
      cause_q <= cause_q | ev_new; // RQ1
  end

  // writable control bits, only taken once ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_sel_q <= 1'b0;
      pol_q       <= 1'b0;
      out_en_q    <= 1'b0;
      drive_q     <= 1'b0;
      energy_en_q <= 1'b0;
      frame_en_q  <= 1'b0;
    end
    else if (wr_fire && ready && hit(apb_req.paddr, `WES_OFF_PWR_CTRL))
    begin
      pulse_sel_q <= apb_req.pwdata[`WES_BIT_PULSE_SEL];
      pol_q       <= apb_req.pwdata[`WES_BIT_POL];
      out_en_q    <= apb_req.pwdata[`WES_BIT_OUT_EN];
      drive_q     <= apb_req.pwdata[`WES_BIT_DRIVE_TYPE];
      energy_en_q <= apb_req.pwdata[`WES_BIT_ENERGY_EN];
      frame_en_q  <= apb_req.pwdata[`WES_BIT_FRAME_EN];
    end
  end

  // power state: software enters low power; byte test write or event wakes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= `WES_MODE_ACTIVE;
    else if (wr_fire && hit(apb_req.paddr, `WES_OFF_BYTE_TEST))
      mode_q <= `WES_MODE_ACTIVE; // RQ18
    else if (event_rise)
      mode_q <= `WES_MODE_ACTIVE;
    else if (wr_fire && ready && hit(apb_req.paddr, `WES_OFF_PWR_CTRL)
             && apb_req.pwdata[`WES_BIT_MODE_HI:`WES_BIT_MODE_LO] != 2'h3) // RQ17
      mode_q <= apb_req.pwdata[`WES_BIT_MODE_HI:`WES_BIT_MODE_LO];
  end

  // readiness sequencer: settle after reset and after each wake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= WES_ST_SETTLE;
      settle_q <= 16'h0;
    end
    else
    begin
      case (state_q)
        WES_ST_SETTLE:
        begin
          if (settle_q >= 16'(SETTLE_CYC - 1))
          begin
            state_q  <= WES_ST_READY;
            settle_q <= 16'h0;
          end
          else
            settle_q <= settle_q + 16'h1;
        end
        WES_ST_READY:
        begin
          if (mode_q != `WES_MODE_ACTIVE)
            state_q <= WES_ST_SLEEP; // RQ12
        end
        WES_ST_SLEEP:
        begin
          if (mode_q == `WES_MODE_ACTIVE)
            state_q <= WES_ST_SETTLE;
        end
        default:
          state_q <= WES_ST_SETTLE;
      endcase
    end
  end

  // enabled wake causes drive the interrupt regardless of pin enable
  assign event_active = (cause_q[0] && energy_en_q) || (cause_q[1] && frame_en_q); // RQ19
  assign power_event_interrupt = event_active;                                    // RQ11

  // rising edge of an enabled cause starts the pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_active_q <= 1'b0;
    else
      event_active_q <= event_active;
  end
  assign event_rise = event_active && !event_active_q;

  // pulse timer, aborted when the cause goes away
  wes_pulse_timer #(.PULSE_CYC(PULSE_CYC)) u_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (event_rise && pulse_sel_q), // RQ5
    .abort   (!event_active),             // RQ7
    .busy    (pulse_busy)
  );

  // pulse mode follows the timer, static mode follows the cause
  assign out_active = out_en_q && (pulse_sel_q ? pulse_busy : event_active); // RQ6 RQ10

  // pin drive: open-drain only pulls low, push-pull honours polarity
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_event_out <= 1'b0;
      power_event_oe  <= 1'b0;
    end
    else if (!drive_q)
    begin
      power_event_out <= 1'b0;       // RQ9
      power_event_oe  <= out_active; // RQ20
    end
    else
    begin
      power_event_out <= pol_q ? out_active : !out_active; // RQ8
      power_event_oe  <= 1'b1;                             // RQ20
    end
  end

  assign power_state_select = mode_q;

  // read data, registered; control register answers in every state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0;
    else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
    begin
      if (hit(apb_req.paddr, `WES_OFF_PWR_CTRL))
        prdata_q <= {18'h0, mode_q, 2'h0, frame_en_q, energy_en_q, 1'b0, drive_q,
                     cause_q, pulse_sel_q, pol_q, out_en_q, ready}; // RQ13
      else if (hit(apb_req.paddr, `WES_OFF_EVENT_SRC))
        prdata_q <= {30'h0, pend_q};
      else
        prdata_q <= 32'h0; // unmapped reads zero
    end
  end
  assign apb_rsp.prdata = prdata_q;

  // zero wait state; error on unmapped or early access to other addresses
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = (rd_fire || wr_fire)
                           && !hit(apb_req.paddr, `WES_OFF_PWR_CTRL)
                           && !(wr_fire && hit(apb_req.paddr, `WES_OFF_BYTE_TEST))
                           && !(ready && hit(apb_req.paddr, `WES_OFF_EVENT_SRC)); // RQ15 RQ16

  // assertions
  property p_pin_off;
    @(posedge pclk) disable iff (!presetn)
    !out_en_q |=> ($past(drive_q) ? (power_event_out == !$past(pol_q)) : !power_event_oe);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin asserted while disabled"); // RQ10

  property p_od_low;
    @(posedge pclk) disable iff (!presetn)
    (!drive_q && $past(!drive_q)) |-> !power_event_out;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drove high"); // RQ9

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    power_event_interrupt == ((cause_q[0] && energy_en_q) || (cause_q[1] && frame_en_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch"); // RQ11

  property p_no_clear_zero;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && !apb_req.pwdata[4] && cause_q[0]) |=> cause_q[0];
  endproperty
  a_no_clear_zero: assert property (p_no_clear_zero) else $error("cause cleared by zero"); // RQ2

  property p_no_clear_unready;
    @(posedge pclk) disable iff (!presetn)
    (!ready && cause_q[1]) |=> cause_q[1];
  endproperty
  a_no_clear_unready: assert property (p_no_clear_unready) else $error("cleared while not ready"); // RQ3

  property p_pending_holds;
    @(posedge pclk) disable iff (!presetn)
    (pend_q[0] && cause_q[0]) |=> cause_q[0];
  endproperty
  a_pending_holds: assert property (p_pending_holds) else $error("cleared with source pending"); // RQ4

  property p_pulse_start;
    @(posedge pclk) disable iff (!presetn)
    (event_rise && pulse_sel_q && out_en_q) |=> pulse_busy [*8];
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse too short"); // RQ5

  property p_static_hold;
    @(posedge pclk) disable iff (!presetn)
    (!pulse_sel_q && out_en_q && event_active) |-> out_active;
  endproperty
  a_static_hold: assert property (p_static_hold) else $error("static output dropped"); // RQ6

  property p_drop;
    @(posedge pclk) disable iff (!presetn)
    (!event_active && $past(!event_active)) |-> !out_active;
  endproperty
  a_drop: assert property (p_drop) else $error("output held without cause"); // RQ7

  property p_ready_sleep;
    @(posedge pclk) disable iff (!presetn)
    (mode_q != `WES_MODE_ACTIVE) |=> !ready;
  endproperty
  a_ready_sleep: assert property (p_ready_sleep) else $error("ready in low power"); // RQ12

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
    (wr_fire && apb_req.paddr == `WES_OFF_BYTE_TEST) |=> (mode_q == `WES_MODE_ACTIVE);
  endproperty
  a_wake: assert property (p_wake) else $error("byte test write did not wake"); // RQ18
endmodule : wes_wake_status

// ---- testbench/wes_host_side.sv ----
`timescale 1ns/10ps
// far side of the event pin: wired line with a pull-up, plus an active-cycle meter
module wes_host_side (
  input  wire logic        pclk,
  input  wire logic        power_event_out,
  input  wire logic        power_event_oe,
  input  wire logic        act_high,
  input  wire logic        clr,
  output logic             pin_level,
  output logic [15:0]      active_cycles
);
  // released line floats to the pull-up, so open-drain idles high
  assign pin_level = power_event_oe ? power_event_out : 1'b1;
  // counts cycles at the active level; clr restarts it so one pulse is measured alone
  always_ff @(posedge pclk)
  begin
    if (clr)
      active_cycles <= 16'h0;
    else if (pin_level == act_high)
      active_cycles <= active_cycles + 16'h1;
  end
endmodule : wes_host_side

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
`include "wes_defines.svh"
module tb_top;
  import wes_pkg::*;
  localparam int unsigned PULSE = 20;  // short pulse so the run stays small
  localparam int unsigned SETTLE = 4;
  localparam logic [11:0] CTRL = `WES_OFF_PWR_CTRL;
  logic         pclk, presetn, energy_pin, frame_pin, irq, pe_out, pe_oe, act_high, clr, pin_level, last_err;
  wes_apb_req_s req;
  wes_apb_rsp_s rsp;
  logic [1:0]   state_sel;
  logic [15:0]  act_cyc;
  logic [31:0]  rdat, c;
  logic [7:0]   seed;
  int           mismatches, tests_run;
  wes_wake_status #(.PULSE_CYC(PULSE), .SETTLE_CYC(SETTLE)) dut_u (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .energy_event_pin(energy_pin),
    .frame_event_pin(frame_pin), .power_event_interrupt(irq), .power_event_out(pe_out),
    .power_event_oe(pe_oe), .power_state_select(state_sel));
  wes_host_side host_u (.pclk(pclk), .power_event_out(pe_out), .power_event_oe(pe_oe),
    .act_high(act_high), .clr(clr), .pin_level(pin_level), .active_cycles(act_cyc));
  // free running clock, 50 ns period
  always #25 pclk = ~pclk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // control word: pulse, polarity, out enable, drive type, energy en, frame en, mode
  function automatic logic [31:0] cfg(input logic p, o, e, d, ee, fe, input logic [1:0] m);
    return {18'h0, m, 2'h0, fe, ee, 1'b0, d, 2'b00, p, o, e, 1'b0};
  endfunction : cfg
  // wire level seen by the far side; only push-pull with polarity set is active high
  function automatic logic exp_pin(input logic d, o, act);
    return (d && o) ? act : !act;
  endfunction : exp_pin
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 100);
    if (rsp.pready !== 1'b1)
      mismatches++; // a slave that never answers fails the run
    rdat = rsp.prdata;
    last_err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  // poll the ready flag; the control register stays readable while settling
  task poll();
    int n;
    n = 0;
    apb(1'b0, CTRL, 32'h0);
    while (rdat[0] !== 1'b1 && n < 50)
    begin
      apb(1'b0, CTRL, 32'h0);
      n++;
    end
    chk("ready", 32'h1, rdat[0]);
  endtask : poll
  // event pin high for a random short span, then time for the cause to land
  task ev(input logic f, input logic e);
    seed = lfsr(seed);
    @(posedge pclk);
    energy_pin <= e;
    frame_pin <= f;
    repeat (seed[1:0] + 1) @(posedge pclk);
    energy_pin <= 1'b0;
    frame_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
  endtask : ev
  task cause(input logic [1:0] exp);
    apb(1'b0, CTRL, 32'h0);
    chk("cause", exp, rdat[5:4]);
  endtask : cause
  task clear_all(input logic [31:0] w);
    apb(1'b1, `WES_OFF_EVENT_SRC, 32'h3);
    apb(1'b1, CTRL, w | 32'h30);
    cause(2'h0);
  endtask : clear_all
  task wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // watchdog well above the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    energy_pin = 1'b0;
    frame_pin = 1'b0;
    act_high = 1'b1;
    clr = 1'b1;
    seed = 8'h2f;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL, 32'h0);
    chk("ready early", 32'h0, rdat[0]);
    poll();
    chk("ctrl reset", 32'h1, rdat);
    apb(1'b0, 12'h0a0, 32'h0);
    chk("unmapped err", 32'h1, last_err);
    // all four drive type and polarity pairs in static mode
    for (int i = 0; i < 4; i++)
    begin
      c = cfg(1'b0, i[0], 1'b1, i[1], 1'b1, 1'b0, 2'h0);
      apb(1'b1, CTRL, c);
      repeat (2) @(negedge pclk);
      chk("pin idle", exp_pin(i[1], i[0], 1'b0), pin_level);
      ev(1'b0, 1'b1);
      chk("irq", 32'h1, irq);
      chk("pin active", exp_pin(i[1], i[0], 1'b1), pin_level);
      apb(1'b1, CTRL, c | 32'h10);
      cause(2'h1);
      apb(1'b1, `WES_OFF_EVENT_SRC, 32'h1);
      apb(1'b1, CTRL, c);
      cause(2'h1);
      clear_all(c);
      @(negedge pclk);
      chk("pin cleared", exp_pin(i[1], i[0], 1'b0), pin_level);
      chk("irq cleared", 32'h0, irq);
    end
    c = cfg(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0);
    apb(1'b1, CTRL, c);
    ev(1'b1, 1'b1);
    cause(2'h3);
    clear_all(c);
    c = cfg(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2'h0);
    apb(1'b1, CTRL, c);
    ev(1'b1, 1'b0);
    cause(2'h2);
    chk("frame pin", 32'h1, pin_level);
    c = cfg(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
    apb(1'b1, CTRL, c);
    repeat (3) @(negedge pclk);
    chk("enable off pin", 32'h0, pin_level);
    clear_all(c);
    c = cfg(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
    apb(1'b1, CTRL, c);
    ev(1'b0, 1'b1);
    chk("irq no out en", 32'h1, irq);
    chk("pin no out en", 32'h0, pin_level);
    clear_all(c);
    // pulse mode: the meter must see exactly one pulse width
    c = cfg(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0);
    apb(1'b1, CTRL, c);
    clr <= 1'b0;
    ev(1'b0, 1'b1);
    repeat (PULSE + 10) @(negedge pclk);
    chk("pulse width", PULSE, act_cyc);
    apb(1'b1, `WES_OFF_EVENT_SRC, 32'h3);
    // low power states with a cause left set
    for (int m = 1; m < 3; m++)
    begin
      apb(1'b1, CTRL, c | (m << 12));
      @(negedge pclk);
      chk("state", m, state_sel);
      apb(1'b0, CTRL, 32'h0);
      chk("ctrl err asleep", 32'h0, last_err);
      chk("mode read", m, rdat[13:12]);
      apb(1'b1, CTRL, c | (m << 12) | 32'h10);
      cause(2'h1);
      seed = lfsr(seed);
      apb(1'b1, `WES_OFF_BYTE_TEST, {4{seed}});
      @(negedge pclk);
      chk("woken state", 32'h0, state_sel);
      poll();
    end
    clear_all(c);
    wrap_up();
  end
endmodule : tb_top
